// ==== hdl/dsc_defs.svh ====
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// register offsets
`define DSC_A_RESET   8'h00
`define DSC_A_CLKOUT  8'h02
`define DSC_A_CALCFG  8'h0e
`define DSC_A_CALCTL  8'h0f
`define DSC_A_MADDR   8'h10
`define DSC_A_MDATA   8'h11
`define DSC_A_QUAD    8'h15
`define DSC_A_SYNC    8'h16

// field positions
`define DSC_B_SWRST   7
`define DSC_B_SDR     7
`define DSC_B_INVCI   5
`define DSC_B_INVCO   4
`define DSC_B_DISCO   3
`define DSC_B_SCDONE  7
`define DSC_B_SCSTART 6
`define DSC_B_XDONE   5
`define DSC_B_XSTART  4
`define DSC_B_SWR     3
`define DSC_B_SRD     2
`define DSC_B_FRD     1
`define DSC_B_FORCE_DEFAULT_CAL   0
`define DSC_B_BYPASS  6
`define DSC_B_EXTQ    5
`define DSC_F_QIN     4:3
`define DSC_F_DIV     2:0

// reset values and masks
`define DSC_RST_CLKOUT 8'h00
`define DSC_CLKOUT_MASK 8'hb8
`define DSC_CAL_DEFAULT 6'h3f

// timing: durations are quoted at a 100 MHz characterisation clock
`define DSC_CAL_MAX_DIV 4096
`define DSC_CHAR_MHZ    100
`define DSC_SELF_CAL_MS 100
`define DSC_XFER_MS     15
`define DSC_SELF_CAL_TICKS (`DSC_SELF_CAL_MS * 1000 * `DSC_CHAR_MHZ / `DSC_CAL_MAX_DIV)
`define DSC_XFER_TICKS (`DSC_XFER_MS * 1000 * `DSC_CHAR_MHZ / `DSC_CAL_MAX_DIV)

`endif

// ==== hdl/dsc_pkg.sv ====
`default_nettype none
package dsc_pkg;

  typedef enum logic [1:0] {
    CAL_FORCE_DEFAULT_CAL,
    CAL_SELF,
    CAL_FACTORY,
    CAL_USER
  } dsc_cal_stat_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SELF,
    ST_XFER
  } dsc_seq_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsc_req_t;

  typedef struct packed {
    logic sclk;
    logic csn;
    logic sdi;
  } dsc_spi_t;

endpackage
`default_nettype wire

// ==== hdl/dsc_cal_div.sv ====
`include "dsc_defs.svh"
`default_nettype none
module dsc_cal_div #(
  parameter int MAX_DIV = `DSC_CAL_MAX_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  import dsc_pkg::*;

  localparam int W = $clog2(MAX_DIV);

  logic [W-1:0] cnt;
  // each step of div_sel halves the period
  wire  [W-1:0] last   = W'((MAX_DIV >> div_sel) - 1);
  wire          at_end = cnt == last;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= at_end;
      cnt  <= at_end ? '0 : cnt + 1'b1;
    end
  end
endmodule // dsc_cal_div
`default_nettype wire

// ==== hdl/dsc_spi_slave.sv ====
`include "dsc_defs.svh"
`default_nettype none
module dsc_spi_slave (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire dsc_pkg::dsc_spi_t spi_pins,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic                   req_stb,
  output dsc_pkg::dsc_req_t      req,
  output logic [7:0]             rd_addr,
  input  wire logic [7:0]        rdata
);
  import dsc_pkg::*;

  dsc_spi_t    s1;
  dsc_spi_t    s2;
  logic        sclk_d;
  logic [3:0]  bitn;
  logic [15:0] shin;
  logic [7:0]  shout;

  wire active = ~s2.csn;
  wire rise   = s2.sclk & ~sclk_d;
  wire fall   = ~s2.sclk & sclk_d;

  // address is complete after eight bits; read data is loaded then
  assign rd_addr = {1'b0, shin[6:0]};
  assign sdo     = shout[7];
  assign sdo_oe  = active;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // idle level of csn is high, so no false select follows reset
      s1     <= '{sclk: 1'b0, csn: 1'b1, sdi: 1'b0};
      s2     <= '{sclk: 1'b0, csn: 1'b1, sdi: 1'b0};
      sclk_d <= 1'b0;
    end
    else
    begin
      s1     <= spi_pins;
      s2     <= s1;
      sclk_d <= s2.sclk;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bitn    <= '0;
      shin    <= '0;
      shout   <= '0;
      req_stb <= 1'b0;
      req     <= '0;
    end
    else
    begin
      req_stb <= 1'b0;
      if (!active)
        bitn <= '0;
      else if (rise)
      begin
        shin <= {shin[14:0], s2.sdi};
        bitn <= bitn + 4'h1;
        // first bit high marks a read; only writes raise the strobe
        if (bitn == 4'hf)
        begin
          req_stb <= ~shin[14];
          req     <= '{addr: {1'b0, shin[13:7]}, wdata: {shin[6:0], s2.sdi}};
        end
      end
      if (active && fall)
        shout <= (bitn == 4'h8) ? rdata : {shout[6:0], 1'b0};
    end
  end
endmodule // dsc_spi_slave
`default_nettype wire

// ==== hdl/dsc_ctrl.sv ====
`include "dsc_defs.svh"
`default_nettype none
module dsc_ctrl #(
  parameter int SELF_TICKS = `DSC_SELF_CAL_TICKS,
  parameter int XFER_TICKS = `DSC_XFER_TICKS
) (
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire dsc_pkg::dsc_spi_t spi_pins,
  output logic                   spi_sdo,
  output logic                   spi_sdo_oe,
  input  wire logic              data_clk_in,
  input  wire logic [15:0]       data_in,
  output logic [15:0]            dac_word,
  output logic                   forwarded_data_clock,
  output logic                   clock_out_oe
);
  import dsc_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  dsc_req_t        req;
  logic            req_stb;
  logic [7:0]      rd_addr;
  logic [7:0]      rdata;
  logic            cal_tick;
  logic [7:0]      clk_cfg;
  logic [3:0]      sync_cfg;
  logic [3:0]      ctl_low;
  logic            self_cal_done;
  logic            transfer_done;
  logic [2:0]      div_sel;
  logic [7:0]      mem_address;
  logic [5:0]      mem_data;
  dsc_cal_stat_t   cal_stat;
  dsc_seq_t        seq;
  logic [11:0]     tick_cnt;
  logic [7:0]      sweep_idx;
  logic            init_sweep;
  logic [1:0]      sync_quadrant_report;
  logic [5:0]      static_cal_memory [0:255];

  // stand-in for the fused factory table; contents are arbitrary
  function automatic logic [5:0] dsc_factory(input logic [7:0] a);
    return a[5:0] ^ 6'h2a;
  endfunction

  dsc_spi_slave u_spi (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .spi_pins (spi_pins),
    .sdo      (spi_sdo),
    .sdo_oe   (spi_sdo_oe),
    .req_stb  (req_stb),
    .req      (req),
    .rd_addr  (rd_addr),
    .rdata    (rdata)
  );

  dsc_cal_div u_div (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .run     (seq != ST_IDLE),
    .div_sel (div_sel),
    .tick    (cal_tick)
  );

  wire wr_rst  = req_stb && req.addr == `DSC_A_RESET && req.wdata[`DSC_B_SWRST];
  wire wr_clk  = req_stb && req.addr == `DSC_A_CLKOUT;
  wire wr_cfg  = req_stb && req.addr == `DSC_A_CALCFG;
  wire wr_ctl  = req_stb && req.addr == `DSC_A_CALCTL;
  wire wr_adr  = req_stb && req.addr == `DSC_A_MADDR;
  wire wr_dat  = req_stb && req.addr == `DSC_A_MDATA;
  wire wr_syn  = req_stb && req.addr == `DSC_A_SYNC;
  wire quiet   = req.wdata[3:0] == 4'h0;
  wire go_self = wr_ctl && req.wdata[`DSC_B_SCSTART] && quiet && seq == ST_IDLE;
  wire go_xfer = wr_ctl && req.wdata[`DSC_B_XSTART] && quiet && seq == ST_IDLE;

  wire [11:0] last_tick = (seq == ST_SELF) ? 12'(SELF_TICKS - 1) : 12'(XFER_TICKS - 1);
  wire        seq_last  = seq != ST_IDLE && cal_tick && tick_cnt == last_tick;
  wire        sweeping  = init_sweep | ctl_low[`DSC_B_FORCE_DEFAULT_CAL];
  wire        xfer_wr   = seq == ST_XFER && cal_tick && tick_cnt < 12'h100;
  wire        sw_wr     = ctl_low[`DSC_B_SWR] && !sweeping && seq == ST_IDLE;
  wire [7:0]  mem_wa    = sweeping ? sweep_idx : xfer_wr ? tick_cnt[7:0] : mem_address;
  wire [5:0]  mem_wd    = sweeping ? `DSC_CAL_DEFAULT
                        : xfer_wr ? dsc_factory(tick_cnt[7:0]) : mem_data;

  always_ff @(posedge ref_clk)
  begin
    if (sweeping | xfer_wr | sw_wr)
      static_cal_memory[mem_wa] <= mem_wd;
  end

  // default sweep, also run once after power-up
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_sweep <= 1'b1;
      sweep_idx  <= '0;
    end
    else if (sweeping)
    begin
      sweep_idx <= sweep_idx + 8'h01;
      if (sweep_idx == 8'hff)
        init_sweep <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq      <= ST_IDLE;
      tick_cnt <= '0;
    end
    else if (wr_rst)
      seq <= ST_IDLE;
    else
    begin
      case (seq)
        ST_IDLE:
        begin
          tick_cnt <= '0;
          if (go_self)
            seq <= ST_SELF;
          else if (go_xfer)
            seq <= ST_XFER;
        end
        default:
        begin
          if (seq_last)
            seq <= ST_IDLE;
          else if (cal_tick)
            tick_cnt <= tick_cnt + 12'h001;
        end
      endcase
    end
  end

  // soft reset keeps memory, reports uncalibrated
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      cal_stat <= CAL_FORCE_DEFAULT_CAL;
    else if (wr_rst || sweeping)
      cal_stat <= CAL_FORCE_DEFAULT_CAL;
    else if (seq_last)
      cal_stat <= (seq == ST_SELF) ? CAL_SELF : CAL_FACTORY;
    else if (sw_wr)
      cal_stat <= CAL_USER;
  end

  // done flags; a completion beats a clearing write
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_low       <= '0;
      self_cal_done <= 1'b0;
      transfer_done <= 1'b0;
    end
    else if (wr_rst)
    begin
      ctl_low       <= '0;
      self_cal_done <= 1'b0;
      transfer_done <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
        ctl_low <= req.wdata[3:0];
      self_cal_done <= (seq_last && seq == ST_SELF)
                     | (self_cal_done & ~(wr_ctl & ~req.wdata[`DSC_B_SCDONE]));
      transfer_done <= (seq_last && seq == ST_XFER)
                     | (transfer_done & ~(wr_ctl & ~req.wdata[`DSC_B_XDONE]));
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mem_address <= '0;
    else if (wr_rst)
      mem_address <= '0;
    else if (wr_adr)
      mem_address <= req.wdata;
  end

  // data register; memory reads take precedence over a write
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mem_data <= '0;
    else if (wr_rst)
      mem_data <= '0;
    else if (ctl_low[`DSC_B_FRD])
      mem_data <= dsc_factory(mem_address);
    else if (ctl_low[`DSC_B_SRD])
      mem_data <= static_cal_memory[mem_address];
    else if (wr_dat)
      mem_data <= req.wdata[5:0];
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_cfg  <= `DSC_RST_CLKOUT;
      sync_cfg <= '0;
      div_sel  <= '0;
    end
    else if (wr_rst)
    begin
      clk_cfg  <= `DSC_RST_CLKOUT;
      sync_cfg <= '0;
      div_sel  <= '0;
    end
    else
    begin
      if (wr_clk)
        clk_cfg <= req.wdata & `DSC_CLKOUT_MASK;
      // external quadrant value stored with mode bits
      if (wr_syn)
        sync_cfg <= req.wdata[6:3];
      if (wr_cfg)
        div_sel <= req.wdata[`DSC_F_DIV];
    end
  end

  always_comb
  begin
    rdata = 8'h00;
    if (rd_addr == `DSC_A_CLKOUT)
      rdata = clk_cfg;
    else if (rd_addr == `DSC_A_CALCFG)
      rdata = {2'b00, cal_stat, 1'b0, div_sel};
    else if (rd_addr == `DSC_A_CALCTL)
      rdata = {self_cal_done, seq == ST_SELF, transfer_done, seq == ST_XFER, ctl_low};
    else if (rd_addr == `DSC_A_MADDR)
      rdata = mem_address;
    else if (rd_addr == `DSC_A_MDATA)
      rdata = {2'b00, mem_data};
    else if (rd_addr == `DSC_A_QUAD)
      rdata = {6'h00, sync_quadrant_report};
    else if (rd_addr == `DSC_A_SYNC)
      rdata = {1'b0, sync_cfg, 3'b000};
  end

  // data path: returned clock and bus are pins, so two flops first
  logic [15:0]      din_s1;
  logic [15:0]      din_s2;
  logic             dci_s1;
  logic             dci_s2;
  logic             dci_s3;
  logic [1:0]       phase;
  logic [1:0]       auto_quad;
  logic [3:0][15:0] pipe;
  logic             half;

  wire bypass = sync_cfg[3];
  wire ext_q  = sync_cfg[2];
  // input clock inversion picks the capture edge
  wire dci_edge = clk_cfg[`DSC_B_INVCI] ? (dci_s3 & ~dci_s2) : (~dci_s3 & dci_s2);
  // external quadrant overrides the automatic one
  wire [1:0] quad_used = ext_q ? sync_cfg[1:0] : auto_quad;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      din_s1 <= '0;
      din_s2 <= '0;
      dci_s1 <= 1'b0;
      dci_s2 <= 1'b0;
      dci_s3 <= 1'b0;
    end
    else
    begin
      din_s1 <= data_in;
      din_s2 <= din_s1;
      dci_s1 <= data_clk_in;
      dci_s2 <= dci_s1;
      dci_s3 <= dci_s2;
    end
  end

  // capture on the returned data clock
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase                <= '0;
      auto_quad            <= '0;
      pipe                 <= '0;
      sync_quadrant_report <= '0;
      dac_word             <= '0;
      half                 <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      half  <= ~half;
      if (dci_edge)
        auto_quad <= phase;
      pipe <= {pipe[2:0], dci_edge ? din_s2 : pipe[0]};
      sync_quadrant_report <= quad_used;
      dac_word <= bypass ? din_s2 : pipe[quad_used];
    end
  end

  // full rate passes the master clock itself; a flop cannot toggle that fast
  wire fdc_raw = clk_cfg[`DSC_B_SDR] ? ref_clk : half;
  assign forwarded_data_clock = (fdc_raw ^ clk_cfg[`DSC_B_INVCO]) & ~clk_cfg[`DSC_B_DISCO];
  assign clock_out_oe = ~clk_cfg[`DSC_B_DISCO];

  mem_write_a: assert property (sw_wr && !wr_rst |=>
    static_cal_memory[$past(mem_address)] == $past(mem_data))
    else $error("static write lost");
  mem_read_a: assert property (ctl_low[`DSC_B_SRD] && !ctl_low[`DSC_B_FRD]
    && !wr_rst |=> mem_data == $past(static_cal_memory[mem_address]))
    else $error("static read wrong");
  fac_read_a: assert property (ctl_low[`DSC_B_FRD] && !wr_rst
    |=> mem_data == dsc_factory($past(mem_address)))
    else $error("factory read wrong");
  force_default_cal_hold_a: assert property (ctl_low[`DSC_B_FORCE_DEFAULT_CAL] && !wr_ctl && !wr_rst
    |=> ctl_low[`DSC_B_FORCE_DEFAULT_CAL] && cal_stat == CAL_FORCE_DEFAULT_CAL)
    else $error("uncalibrated mode dropped");
  quad_ext_a: assert property (ext_q && !wr_syn && !wr_rst ##1 ext_q
    |=> sync_quadrant_report == $past(sync_cfg[1:0], 2))
    else $error("external quadrant not applied");
  bypass_path_a: assert property (bypass |=> dac_word == $past(din_s2))
    else $error("bypass data wrong");
  soft_reset_a: assert property (wr_rst |=> cal_stat == CAL_FORCE_DEFAULT_CAL
    && seq == ST_IDLE && ctl_low == 4'h0)
    else $error("soft reset incomplete");
  start_gate_a: assert property (seq == ST_IDLE && wr_ctl && !quiet
    |=> seq == ST_IDLE)
    else $error("cycle started with low bits set");
  done_flag_a: assert property (seq_last && !wr_rst |=>
    (self_cal_done || transfer_done) && seq == ST_IDLE)
    else $error("done flag missing");
  clk_off_a: assert property (clk_cfg[`DSC_B_DISCO]
    |-> !forwarded_data_clock && !clock_out_oe)
    else $error("clock output not disabled");

  cov_self: cover property (seq == ST_SELF ##1 seq == ST_IDLE);
  cov_xfer: cover property (xfer_wr ##[1:1000] transfer_done);
  cov_byp: cover property (bypass && dci_edge);
endmodule // dsc_ctrl
`default_nettype wire

// ==== testbench/dsc_source_model.sv ====
`default_nettype none
module dsc_source_model (
  input  wire logic        fwd_clk,
  input  wire logic        fwd_oe,
  input  wire logic [7:0]  lag_ns,
  input  wire logic        hold_en,
  input  wire logic [15:0] hold_word,
  output logic             data_clk,
  output logic [15:0]      data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    data_clk = 1'b0;
    data     = 16'h0000;
  end

  // same rate returned
  // a source without the forwarded clock has nothing to return, so it stands still
  always @(fwd_clk or fwd_oe)
    data_clk <= #(lag_ns) fwd_clk & fwd_oe;

  // word with clock
  // free-running words change every rising edge so stale data never passes as fresh
  always @(posedge data_clk)
    data <= hold_en ? hold_word : ({data[14:0], ~data[15]} ^ 16'h2d00);
endmodule // dsc_source_model
`default_nettype wire

// ==== testbench/tb.sv ====
`include "dsc_defs.svh"
`default_nettype none
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; $display("Error %s expected %h seen %h", what, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;
  localparam int XFER_T = 260;
  localparam int DIV7   = 32;
  logic             ref_clk, rstn, data_clk_in, spi_sdo, fwd, fwd_oe, hold_en;
  logic [15:0]      data_in, dac_word, hold_word;
  logic [7:0]       lag_ns, q, a, v;
  logic [5:0]       d;
  dsc_spi_t         spi;
  integer           seed;
  int               errors, compares, cyc, t0;
  logic [7:0]       cv [6] = '{8'h80, 8'h90, 8'h00, 8'h10, 8'h08, 8'hff};

  dsc_ctrl #(.SELF_TICKS(4), .XFER_TICKS(XFER_T)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .spi_pins(spi), .spi_sdo(spi_sdo), .spi_sdo_oe(),
    .data_clk_in(data_clk_in), .data_in(data_in), .dac_word(dac_word),
    .forwarded_data_clock(fwd), .clock_out_oe(fwd_oe));

  dsc_source_model src (
    .fwd_clk(fwd), .fwd_oe(fwd_oe), .lag_ns(lag_ns), .hold_en(hold_en),
    .hold_word(hold_word), .data_clk(data_clk_in), .data(data_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    cyc <= cyc + 1;

  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // six cycles per sclk phase leaves room for the two-flop sync and sdo latency
  task automatic frame(input logic rd, input logic [7:0] ad, input logic [7:0] wd,
                       output logic [7:0] r);
    logic [15:0] f;
    f = {rd, ad[6:0], wd};
    r = 8'h00;
    spi.csn = 1'b0;
    ticks(6);
    for (int i = 15; i >= 0; i--)
    begin
      spi.sdi = f[i];
      ticks(6);
      if (i < 8)
        r[i] = spi_sdo;
      spi.sclk = 1'b1;
      ticks(6);
      spi.sclk = 1'b0;
    end
    ticks(6);
    spi.csn = 1'b1;
    ticks(6);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    frame(1'b0, ad, wd, q);
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e,
                      input string what);
    logic [7:0] r;
    frame(1'b1, ad, 8'h00, r);
    `CHK(what, e, r & m)
  endtask

  task automatic poll(input logic [7:0] ad, input int b, input int bound);
    logic [7:0] r;
    r = 8'h00;
    for (int n = 0; n < bound && r[b] !== 1'b1; n++)
      frame(1'b1, ad, 8'h00, r);
    if (r[b] !== 1'b1)
    begin
      errors++;
      $display("Error poll of %h expected 1 seen %b", ad, r[b]);
      report_and_stop();
    end
  endtask

  task automatic memchk(input logic [7:0] ad, input logic [7:0] ctl, input logic [5:0] e,
                        input string what);
    wr(`DSC_A_MADDR, ad);
    wr(`DSC_A_CALCTL, ctl);
    wr(`DSC_A_CALCTL, ctl & 8'h01);
    rchk(`DSC_A_MDATA, 8'hff, {2'b00, e}, what);
  endtask

  function automatic logic [5:0] fact(input logic [7:0] ad);
    return ad[5:0] ^ 6'h2a;
  endfunction

  task automatic clkchk(input logic [7:0] cfg);
    logic p, r;
    wr(`DSC_A_CLKOUT, cfg);
    rchk(`DSC_A_CLKOUT, 8'hff, cfg & `DSC_CLKOUT_MASK, "clock cfg");
    `CHK("clock oe", ~cfg[3], fwd_oe)
    @(posedge ref_clk);
    #25 p = fwd;
    @(posedge ref_clk);
    #25 r = fwd;
    if (!cfg[3])
    begin
      if (cfg[7])
        `CHK("single rate phase", ~cfg[4], p)
      else
        `CHK("double rate toggle", ~p, r)
    end
  endtask

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    seed = 32'h4905;
    errors = 0;
    compares = 0;
    cyc = 0;
    rstn = 1'b0;
    spi.sclk = 1'b0;
    spi.csn = 1'b1;
    spi.sdi = 1'b0;
    lag_ns = 8'd5;
    hold_en = 1'b0;
    hold_word = 16'h0000;
    ticks(6);
    rstn = 1'b1;
    rchk(`DSC_A_MADDR, 8'hff, 8'h00, "addr reset");
    rchk(`DSC_A_MDATA, 8'hff, 8'h00, "data reset");
    rchk(`DSC_A_SYNC, 8'hff, 8'h00, "sync reset");
    rchk(`DSC_A_CLKOUT, 8'hff, `DSC_RST_CLKOUT, "clock reset");
    wr(8'h7f, 8'h5a);
    rchk(8'h7f, 8'hff, 8'h00, "unmapped");
    done_test("reset");
    foreach (cv[k])
      clkchk(cv[k]);
    done_test("clock out");
    for (int k = 0; k < 4; k++)
    begin
      v = 8'h20 | 8'(k << 3);
      lag_ns = 8'(k * 30);
      wr(`DSC_A_CLKOUT, k[0] ? 8'h20 : 8'h00);
      wr(`DSC_A_SYNC, v);
      ticks(10);
      rchk(`DSC_A_QUAD, 8'hff, 8'(k), "quadrant used");
      rchk(`DSC_A_SYNC, 8'hff, v, "sync cfg");
    end
    done_test("quadrant");
    hold_en = 1'b1;
    wr(`DSC_A_SYNC, 8'h40);
    wr(`DSC_A_CLKOUT, 8'h80);
    for (int k = 0; k < 3; k++)
    begin
      hold_word = 16'($random(seed));
      ticks(8);
      `CHK("bypass word", hold_word, dac_word)
    end
    wr(`DSC_A_SYNC, 8'h00);
    hold_en = 1'b0;
    done_test("bypass");
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 8'hff : 8'($random(seed));
      d = 6'($random(seed));
      wr(`DSC_A_MADDR, a);
      wr(`DSC_A_MDATA, {2'b00, d});
      wr(`DSC_A_CALCTL, 8'h08);
      wr(`DSC_A_CALCTL, 8'h00);
      wr(`DSC_A_MDATA, {2'b00, ~d});
      memchk(a, 8'h04, d, "mem write");
    end
    rchk(`DSC_A_CALCFG, 8'h30, 8'h30, "status user");
    done_test("memory");
    wr(`DSC_A_CALCFG, 8'h07);
    wr(`DSC_A_RESET, 8'h80);
    rchk(`DSC_A_RESET, 8'hff, 8'h00, "soft reset bit");
    rchk(`DSC_A_CALCFG, 8'hff, 8'h00, "status force_default_cal");
    memchk(a, 8'h04, d, "mem kept");
    done_test("soft reset");
    wr(`DSC_A_CALCTL, 8'h01);
    ticks(300);
    memchk(a, 8'h05, `DSC_CAL_DEFAULT, "default entry");
    rchk(`DSC_A_CALCTL, 8'hff, 8'h01, "force held");
    rchk(`DSC_A_CALCFG, 8'h30, 8'h00, "status defaults");
    done_test("defaults");
    wr(`DSC_A_CALCFG, 8'h07);
    wr(`DSC_A_CALCTL, 8'h41);
    rchk(`DSC_A_CALCTL, 8'hff, 8'h01, "self start refused");
    wr(`DSC_A_CALCTL, 8'h40);
    poll(`DSC_A_CALCTL, 7, 5);
    rchk(`DSC_A_CALCTL, 8'hc0, 8'h80, "self done");
    rchk(`DSC_A_CALCFG, 8'h30, 8'h10, "status self");
    wr(`DSC_A_CALCTL, 8'h00);
    done_test("self cal");
    wr(`DSC_A_CALCTL, 8'h14);
    rchk(`DSC_A_CALCTL, 8'hff, 8'h04, "xfer start refused");
    wr(`DSC_A_CALCTL, 8'h10);
    t0 = cyc;
    rchk(`DSC_A_CALCTL, 8'h30, 8'h10, "xfer running");
    poll(`DSC_A_CALCTL, 5, 80);
    `CHK("xfer time", 1'b1, (cyc - t0 >= XFER_T * DIV7 - 40) && (cyc - t0 <= XFER_T * DIV7 + 600))
    rchk(`DSC_A_CALCTL, 8'h30, 8'h20, "xfer done");
    rchk(`DSC_A_CALCFG, 8'h30, 8'h20, "status factory");
    for (int k = 0; k < 3; k++)
    begin
      a = 8'($random(seed));
      memchk(a, 8'h04, fact(a), "copied entry");
      memchk(a, 8'h02, fact(a), "factory read");
    end
    done_test("transfer");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
